// ==== shared/startup_pkg.sv ====
// constants, state type and the millisecond bucket decoder for the start-up supervisor
// assumes a 40 MHz core clock and command words already framed by the bus engine
package startup_pkg;
   // command codes of the three settings
   localparam logic [7:0]  CMD_RAMP_TIME = 8'h61;
   localparam logic [7:0]  CMD_LIMIT     = 8'h62;
   localparam logic [7:0]  CMD_ACTION    = 8'h63;
   // reset values
   localparam logic [15:0] RAMP_RST      = 16'h0005;
   localparam logic [15:0] LIMIT_RST     = 16'h0064;
   localparam logic [7:0]  ACTION_RST    = 8'hbf;
   // field layout of the linear words and the action byte
   localparam int          MANT_W        = 7;
   localparam int          WORD_W        = 16;
   localparam int          RSP_BIT       = 7;
   localparam int          RS_MSB        = 5;
   localparam int          RS_LSB        = 3;
   localparam logic [2:0]  RS_LATCH      = 3'h0;
   localparam logic [2:0]  RS_RETRY      = 3'h7;
   localparam logic [2:0]  HARD_DELAY    = 3'h7;
   localparam logic [9:0]  RESTART_MULT  = 10'h007;
   localparam logic [6:0]  MANT_ZERO     = 7'h00;
   localparam logic [6:0]  MANT_MAX      = 7'h7f;
   localparam logic [6:0]  EFF_MIN       = 7'h01;
   localparam logic [6:0]  EFF_MAX       = 7'h64;
   // time base
   localparam int          MS_NS         = 1000000;
   localparam int          CLK_NS        = 25;
   localparam int          TICK_CYCLES   = (MS_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {ST_IDLE, ST_RAMP, ST_RUN, ST_WAIT, ST_HOLD} seq_state_e;

   // programmed mantissa to one of the supported millisecond times
   function automatic logic [6:0] quantize(input logic [6:0] m);
      logic [6:0] q;
      q = 7'h64;
      if (m <= 7'h01) q = 7'h01;
      else if (m <= 7'h06) q = m;
      else if (m <= 7'h09) q = 7'h07;
      else if (m <= 7'h0c) q = 7'h0a;
      else if (m <= 7'h11) q = 7'h0e;
      else if (m <= 7'h16) q = 7'h13;
      else if (m <= 7'h20) q = 7'h1b;
      else if (m <= 7'h2c) q = 7'h25;
      else if (m <= 7'h3e) q = 7'h34;
      else if (m <= 7'h56) q = 7'h48;
      return q;
   endfunction
endpackage

// ==== src/ms_tick_gen.sv ====
// millisecond tick prescaler
// assumes a free running core clock; ce low freezes the count
`timescale 1ns/10ps
module ms_tick_gen #(
   parameter int unsigned CYCLES = 40000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   output logic      tick_q
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q;   // cycles since the last tick
   wire           wrap = (cnt_q == CW'(CYCLES - 1));

   // one-cycle tick every CYCLES clocks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         tick_q <= wrap;
      end
   end
endmodule

// ==== src/startup_timeout_supervisor.sv ====
// start-up timeout supervisor: ramp and timeout settings, timer, fault response
// assumes framed command writes on this clock and a raw analog undervoltage-clear pin
`timescale 1ns/10ps
// Behaviour
// - exponent fields read zero, one count one ms
// - ramp mantissa 7 writable bits, resets to 5
// - ramp mantissa quantized to supported ms buckets
// - timeout bounds time to clear undervoltage
// - timer starts on entering soft-start ramp
// - timeout below ramp time rejected, flags set
// - zero timeout disables timer and cross check
// - timeout word linear, exponent read only
// - timeout mantissa 7 writable bits, resets 100
// - restore-all reloads timeout to 100 ms
// - timeout quantized alike, zero means none
// - fault sets three status bits, alert
// - action byte saved on store-all command
// - action bits 2:0 hard-wired to seven
// - default response: shut down, retry later
// - select zero ignores, one shuts down
// - retry 000 latches off, 111 retries
// - other retry values rejected with flags
// - ramp time runs reference start to band
module startup_timeout_supervisor
   import startup_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = startup_pkg::TICK_CYCLES
) (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           ce,
   input  wire logic                           cmd_wr,
   input  wire logic [7:0]                     cmd_code,
   input  wire logic [startup_pkg::WORD_W-1:0] cmd_data,
   input  wire logic                           store_all,
   input  wire logic                           restore_all,
   input  wire logic                           clear_faults,
   input  wire logic                           power_on,
   input  wire logic                           ramp_start,
   input  wire logic                           uv_clear_pin,
   output logic [startup_pkg::WORD_W-1:0]      ramp_time_q,
   output logic [startup_pkg::WORD_W-1:0]      limit_q,
   output logic [7:0]                          action_q,
   output logic [7:0]                          nvm_action_q,
   output logic                                nvm_save_q,
   output logic                                ramp_active_q,
   output logic                                output_enable_q,
   output logic                                restart_q,
   output logic                                status_other_q,
   output logic                                output_warning_summary_q,
   output logic                                startup_timeout_flag_q,
   output logic                                status_cml_q,
   output logic                                invalid_data_q,
   output logic                                smbalert_q
);
   import startup_pkg::*;

   localparam logic [WORD_W-MANT_W-1:0] TOP_ZERO = '0;

   seq_state_e st_q, st_d;       // sequencer state
   logic [6:0] elapsed_q;        // ms since the ramp began
   logic [9:0] wait_q;           // ms spent in the restart delay
   logic       sync1_q;          // pin synchroniser, first stage
   logic       sync2_q;          // second stage
   logic       sync3_q;          // third stage
   logic       uv_ok_q;          // filtered undervoltage-cleared level
   logic       tick_q;           // millisecond tick

   // prescaler for the millisecond time base
   ms_tick_gen #(
      .CYCLES (TICK_CYCLES_P)
   ) u_tick (
      .clk    (clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .tick_q (tick_q)
   );

   // command decode
   wire       wr_ramp  = cmd_wr && (cmd_code == CMD_RAMP_TIME);
   wire       wr_lim   = cmd_wr && (cmd_code == CMD_LIMIT);
   wire       wr_act   = cmd_wr && (cmd_code == CMD_ACTION);
   wire [6:0] new_mant = cmd_data[MANT_W-1:0];
   wire [2:0] rs_new   = cmd_data[RS_MSB:RS_LSB];
   wire [6:0] ramp_m   = ramp_time_q[MANT_W-1:0];
   wire [6:0] lim_m    = limit_q[MANT_W-1:0];
   wire [2:0] rs_cur   = action_q[RS_MSB:RS_LSB];

   // cross checks between the two settings, then the retry-code check; a zero timeout waives only the cross checks
   wire lim_bad  = wr_lim && (new_mant != MANT_ZERO) && (new_mant < ramp_m);
   wire ramp_bad = wr_ramp && (lim_m != MANT_ZERO) && (new_mant > lim_m);
   wire act_bad  = wr_act && (rs_new != RS_LATCH) && (rs_new != RS_RETRY);
   wire cml_set  = lim_bad || ramp_bad || act_bad;

   // effective times in ms
   wire [6:0] eff_rise  = quantize(ramp_m);
   wire [6:0] eff_lim   = quantize(lim_m);
   wire       timer_on  = (lim_m != MANT_ZERO);
   wire [9:0] delay_ms  = 10'(eff_rise) * RESTART_MULT;

   // timeout: limit reached while undervoltage is still not cleared
   wire fault_evt = (st_q == ST_RAMP) && timer_on && !uv_ok_q
                    && (elapsed_q >= eff_lim);
   wire wait_done = (st_q == ST_WAIT) && (wait_q >= delay_ms);

   // sequencer next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (power_on && ramp_start) st_d = ST_RAMP;
         end
         ST_RAMP: begin
            if (fault_evt) begin
               if (!action_q[RSP_BIT]) st_d = ST_RUN;
               else if (rs_cur == RS_RETRY) st_d = ST_WAIT;
               else st_d = ST_HOLD;
            end else if (uv_ok_q) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN:  st_d = ST_RUN;
         ST_WAIT: begin
            if (wait_done) st_d = ST_RAMP;
         end
         ST_HOLD: begin
            if (clear_faults) st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
      if (!power_on) st_d = ST_IDLE;
   end

   // next register values; restore-all outranks a timeout or action write in the same cycle, ramp writes go through
   wire [15:0] limit_d = restore_all ? LIMIT_RST :
                         (wr_lim && !lim_bad) ? {TOP_ZERO, new_mant} : limit_q;
   wire [15:0] ramp_d  = (wr_ramp && !ramp_bad) ? {TOP_ZERO, new_mant}
                                                : ramp_time_q;
   wire [7:0]  act_w   = {cmd_data[RSP_BIT], 1'b0, rs_new, HARD_DELAY};
   wire [7:0]  act_d   = restore_all ? nvm_action_q :
                         (wr_act && !act_bad) ? act_w : action_q;
   wire        keep    = !clear_faults;
   wire        uv_d    = (sync2_q == sync3_q) ? sync3_q : uv_ok_q;

   // pin synchroniser and agreement filter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         uv_ok_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= uv_clear_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         uv_ok_q <= uv_d;
      end
   end

   // settings registers and non-volatile image of the action byte
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ramp_time_q  <= RAMP_RST;
         limit_q      <= LIMIT_RST;
         action_q     <= ACTION_RST;
         nvm_action_q <= ACTION_RST;
         nvm_save_q   <= 1'b0;
      end else if (ce) begin
         ramp_time_q  <= ramp_d;
         limit_q      <= limit_d;
         action_q     <= act_d;
         nvm_action_q <= store_all ? action_q : nvm_action_q;
         nvm_save_q   <= store_all;
      end
   end

   // sequencer and millisecond counters; both counters only count up on the tick
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q      <= ST_IDLE;
         elapsed_q <= MANT_ZERO;
         wait_q    <= '0;
      end else if (ce) begin
         st_q      <= st_d;
         elapsed_q <= (st_d == ST_RAMP && st_q != ST_RAMP) ? MANT_ZERO :
                      (tick_q && elapsed_q != MANT_MAX) ? elapsed_q + 1'b1 :
                      elapsed_q;
         wait_q    <= (st_q != ST_WAIT) ? '0 : tick_q ? wait_q + 1'b1 : wait_q;
      end
   end

   // outputs toward the power stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ramp_active_q   <= 1'b0;
         output_enable_q <= 1'b0;
         restart_q       <= 1'b0;
      end else if (ce) begin
         ramp_active_q   <= (st_d == ST_RAMP) && (elapsed_q < eff_rise);
         output_enable_q <= (st_d == ST_RAMP) || (st_d == ST_RUN);
         restart_q       <= wait_done && power_on;
      end
   end

   // sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_other_q           <= 1'b0;
         output_warning_summary_q <= 1'b0;
         startup_timeout_flag_q   <= 1'b0;
         status_cml_q             <= 1'b0;
         invalid_data_q           <= 1'b0;
         smbalert_q               <= 1'b0;
      end else if (ce) begin
         status_other_q           <= fault_evt || (status_other_q && keep);
         output_warning_summary_q <= fault_evt || (output_warning_summary_q && keep);
         startup_timeout_flag_q   <= fault_evt || (startup_timeout_flag_q && keep);
         status_cml_q             <= cml_set || (status_cml_q && keep);
         invalid_data_q           <= cml_set || (invalid_data_q && keep);
         smbalert_q               <= fault_evt || cml_set || (smbalert_q && keep);
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence fault_retry_s;
      ce && power_on && fault_evt && action_q[RSP_BIT] && (rs_cur == RS_RETRY);
   endsequence
   sequence fault_latch_s;
      ce && power_on && fault_evt && action_q[RSP_BIT] && (rs_cur == RS_LATCH);
   endsequence

   expo_zero_a: assert property ((limit_q[WORD_W-1:MANT_W] == '0)
      && (ramp_time_q[WORD_W-1:MANT_W] == '0)) else $error("exponent or top bits nonzero");
   // buckets round both ways above six, so only the one-to-one span is exact
   rise_bucket_a: assert property ((eff_rise >= EFF_MIN) && (eff_rise <= EFF_MAX)
      && ((ramp_m > 7'h06) || (eff_rise == ((ramp_m == MANT_ZERO) ? EFF_MIN : ramp_m))))
      else $error("ramp bucket out of range");
   low_limit_a: assert property (ce && lim_bad && !restore_all |=>
      limit_q == $past(limit_q) && invalid_data_q && smbalert_q) else $error("low timeout kept");
   zero_off_a: assert property (lim_m == MANT_ZERO |-> !fault_evt)
      else $error("fault with timer off");
   restore_lim_a: assert property (ce && restore_all |=> limit_q == LIMIT_RST)
      else $error("restore missed timeout default");
   hard_bits_a: assert property (action_q[2:0] == HARD_DELAY && !action_q[6])
      else $error("action fixed bits changed");
   fault_flags_a: assert property (ce && fault_evt |=> status_other_q
      && output_warning_summary_q && startup_timeout_flag_q && smbalert_q)
      else $error("timeout fault flags missing");
   retry_rej_a: assert property (ce && act_bad && !restore_all |=>
      action_q == $past(action_q) && status_cml_q) else $error("bad retry value kept");
   ignore_run_a: assert property (ce && power_on && fault_evt && !action_q[RSP_BIT]
      |=> st_q == ST_RUN) else $error("ignore mode left run");
   retry_wait_a: assert property (fault_retry_s |=> st_q == ST_WAIT [*2])
      else $error("retry did not wait");
   latch_hold_a: assert property (fault_latch_s |=> st_q == ST_HOLD)
      else $error("latch mode not held");
   ramp_start_a: assert property (ce && st_q == ST_IDLE && power_on && ramp_start
      |=> st_q == ST_RAMP && elapsed_q == MANT_ZERO) else $error("timer start wrong");
   fault_uv_a: assert property (fault_evt |-> !uv_ok_q && elapsed_q >= eff_lim)
      else $error("fault without cause");
   tick_only_a: assert property (ce && st_q == ST_RAMP && !tick_q ##1 st_q == ST_RAMP
      |-> elapsed_q == $past(elapsed_q)) else $error("counter moved without tick");
   ramp_flag_a: assert property (ce && st_d == ST_RAMP && elapsed_q < eff_rise
      |=> ramp_active_q) else $error("ramp active missing");
   save_act_a: assert property (ce && store_all |=> nvm_save_q
      && nvm_action_q == $past(action_q)) else $error("store-all missed");
endmodule

// ==== dv/uv_monitor_model.sv ====
// behavioural model of the analog undervoltage monitor beside the supervisor
// assumes output_enable_q of the supervisor stands for the power stage being on
`timescale 1ns/10ps
module uv_monitor_model #(
   parameter int TICKS = 4 // cycles per shortened millisecond
) (
   input  wire logic clk,
   input  wire logic output_enable_q,
   input  wire logic [31:0] clear_ms,
   output logic      uv_clear_pin
);
   int cnt; // cycles since the stage was enabled

   // ramp progress: restarts whenever the stage is switched off
   always_ff @(posedge clk) begin
      if (!output_enable_q) cnt <= 0;
      else cnt <= cnt + 1;
   end

   // zero ms means the output never climbs out of undervoltage;
   // a stage that is off lets the output fall, so the pin drops at once
   assign uv_clear_pin = output_enable_q && clear_ms != 0 && cnt >= clear_ms * TICKS;
endmodule

// ==== dv/startup_timeout_supervisor_bench.sv ====
// self-checking bench for the start-up timeout supervisor
// assumes a shortened tick of 4 cycles, so one ms is 4 clocks here
`timescale 1ns/10ps
module startup_timeout_supervisor_bench;
   import startup_pkg::*;
   localparam int TK = 4; // shortened ms, keeps 100 ms runs brief
   logic        clk, rst_n, ce, cmd_wr, store_all, restore_all, clear_faults;
   logic        power_on, ramp_start, uv_clear_pin, nvm_save_q, ramp_active_q;
   logic        output_enable_q, restart_q, status_other_q, output_warning_summary_q;
   logic        startup_timeout_flag_q, status_cml_q, invalid_data_q, smbalert_q;
   logic [7:0]  cmd_code, action_q, nvm_action_q, exp_act;
   logic [15:0] cmd_data, ramp_time_q, limit_q;
   int          uv_ms, err_count, total_checks, n;
   int          lm[4] = '{1, 8, 40, 90};  // limit mantissas, one per bucket kind
   int          ef[4] = '{1, 7, 37, 100}; // their effective ms

   startup_timeout_supervisor #(.TICK_CYCLES_P(TK)) startup_timeout_supervisor_inst (
      .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .store_all(store_all), .restore_all(restore_all),
      .clear_faults(clear_faults), .power_on(power_on), .ramp_start(ramp_start),
      .uv_clear_pin(uv_clear_pin), .ramp_time_q(ramp_time_q), .limit_q(limit_q),
      .action_q(action_q), .nvm_action_q(nvm_action_q), .nvm_save_q(nvm_save_q),
      .ramp_active_q(ramp_active_q), .output_enable_q(output_enable_q),
      .restart_q(restart_q), .status_other_q(status_other_q),
      .output_warning_summary_q(output_warning_summary_q),
      .startup_timeout_flag_q(startup_timeout_flag_q), .status_cml_q(status_cml_q),
      .invalid_data_q(invalid_data_q), .smbalert_q(smbalert_q));

   uv_monitor_model #(.TICKS(TK)) uv_monitor_model_inst (
      .clk(clk), .output_enable_q(output_enable_q), .clear_ms(uv_ms),
      .uv_clear_pin(uv_clear_pin));

   // free running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi, input string what);
      chk({15'h0, (v >= lo && v <= hi)}, 16'h0001, what);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one command write; the register shows the result right after the edge
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd_wr = 1'b1;
      cmd_code = c;
      cmd_data = d;
      cyc(1);
      cmd_wr = 1'b0;
   endtask

   task automatic pulse_clear;
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
   endtask

   // back to idle with clean flags, then enter the soft-start ramp
   task automatic go;
      power_on = 1'b0;
      pulse_clear();
      power_on = 1'b1;
      ramp_start = 1'b1;
      cyc(1);
      ramp_start = 1'b0;
   endtask

   // bounded wait for the timeout flag (w 0) or the restart pulse (w 1)
   task automatic wait_for(input int w, input int lim, output int k);
      k = 1;
      while ((w == 0 ? startup_timeout_flag_q : restart_q) !== 1'b1) begin
         cyc(1);
         k++;
         if (k > lim) begin
            err_count++;
            $display("[FAIL] %0t wait ran out", $time);
            wrap_up();
         end
      end
   endtask

   initial begin
      rst_n = 1'b0; ce = 1'b1; cmd_wr = 1'b0; cmd_code = 8'h00; cmd_data = 16'h0000;
      store_all = 1'b0; restore_all = 1'b0; clear_faults = 1'b0; power_on = 1'b0;
      ramp_start = 1'b0; uv_ms = 0; err_count = 0; total_checks = 0; exp_act = ACTION_RST;
      cyc(5);
      rst_n = 1'b1;
      chk(ramp_time_q, 16'h0005, "ramp reset");
      chk(limit_q, 16'h0064, "limit reset");
      chk({8'h00, action_q}, 16'h00bf, "action reset");
      $display("test reset values done");
      // a limit under the ramp time is discarded and flagged
      wr(CMD_LIMIT, 16'hff84);
      chk(limit_q, 16'h0064, "low limit kept");
      chk({13'h0, status_cml_q, invalid_data_q, smbalert_q}, 16'h0007, "reject flags");
      pulse_clear();
      wr(CMD_LIMIT, 16'hffff);
      chk(limit_q, 16'h007f, "limit masked");
      wr(CMD_RAMP_TIME, 16'hff8a);
      chk(ramp_time_q, 16'h000a, "ramp masked");
      // zero limit switches the cross check off
      wr(CMD_LIMIT, 16'h0000);
      wr(CMD_RAMP_TIME, 16'h007f);
      chk(ramp_time_q, 16'h007f, "ramp unchecked");
      chk({15'h0, status_cml_q}, 16'h0000, "no reject");
      restore_all = 1'b1;
      cyc(1);
      restore_all = 1'b0;
      chk(limit_q, 16'h0064, "limit restored");
      wr(CMD_RAMP_TIME, 16'h0001);
      $display("test cross checks done");
      // every retry code; bits 2:0 and bit 6 written as the inverse of what reads back
      for (int r = 0; r < 8; r++) begin
         pulse_clear();
         wr(CMD_ACTION, {8'h00, 2'b11, r[2:0], 3'b000});
         if (r == 0 || r == 7) exp_act = {2'b10, r[2:0], 3'b111};
         chk({8'h00, action_q}, {8'h00, exp_act}, "action write");
         chk({15'h0, invalid_data_q}, {15'h0, (r != 0 && r != 7)}, "retry reject");
      end
      wr(CMD_ACTION, 16'h0000);
      store_all = 1'b1;
      cyc(1);
      store_all = 1'b0;
      chk({7'h0, nvm_save_q, nvm_action_q}, 16'h0107, "store image");
      cyc(1);
      chk({15'h0, nvm_save_q}, 16'h0000, "save pulse ends");
      wr(CMD_ACTION, 16'h00b8);
      $display("test action byte done");
      // timeout span per bucket, counted from entry into the ramp
      for (int i = 0; i < 4; i++) begin
         wr(CMD_LIMIT, lm[i][15:0]);
         go();
         wait_for(0, 500, n);
         rng(n, TK * (ef[i] - 1) + 1, TK * ef[i] + 3, "timeout span");
      end
      chk({12'h0, status_other_q, output_warning_summary_q, startup_timeout_flag_q,
           smbalert_q}, 16'h000f, "fault flags");
      cyc(1);
      chk({15'h0, output_enable_q}, 16'h0000, "shut down");
      // restart after seven effective ramp times, ramp mantissa 1 and 8
      wr(CMD_LIMIT, 16'h0008);
      for (int i = 0; i < 2; i++) begin
         wr(CMD_RAMP_TIME, lm[i][15:0]);
         go();
         wait_for(0, 500, n);
         wait_for(1, 500, n);
         rng(n, 7 * ef[i] * TK - 4, 7 * ef[i] * TK + 6, "restart delay");
      end
      $display("test timer done");
      // select zero keeps running but still reports
      wr(CMD_ACTION, 16'h0038);
      go();
      wait_for(0, 500, n);
      cyc(3);
      chk({14'h0, output_enable_q, smbalert_q}, 16'h0003, "ignore mode");
      // retry 000 holds off until the fault is cleared
      wr(CMD_ACTION, 16'h0080);
      go();
      wait_for(0, 500, n);
      cyc(60);
      chk({14'h0, restart_q, output_enable_q}, 16'h0000, "latched off");
      pulse_clear();
      ramp_start = 1'b1;
      cyc(1);
      ramp_start = 1'b0;
      cyc(1);
      chk({14'h0, ramp_active_q, output_enable_q}, 16'h0003, "released");
      // output reaches its band in time: no fault
      wr(CMD_ACTION, 16'h00b8);
      wr(CMD_LIMIT, 16'h000a);
      uv_ms = 1;
      go();
      cyc(80);
      chk({14'h0, startup_timeout_flag_q, output_enable_q}, 16'h0001, "in time");
      // zero limit: no timer at all
      uv_ms = 0;
      wr(CMD_LIMIT, 16'h0000);
      go();
      cyc(450);
      chk({14'h0, startup_timeout_flag_q, output_enable_q}, 16'h0001, "no limit");
      $display("test sequencer done");
      wrap_up();
   end
endmodule
